/* design/high_side_switch_cyclic_control.sv */
// Notes on behaviour
// - timer b on-time codes 1..5 give 0.1/0.3/1/10/20 ms; 0 stops low; 7 reserved.
// - on-time code 110 halts timer b and holds its switches on.
// - timer b period codes 0..6 give 10/20/50/100/200/1000/2000 ms; 7 reserved.
// - software assigns a timer first; writing a running on-time starts it.
// - restart clear with cyclic sensing also clears that timer's fields.
// - reserved bits of timer, shutdown and switch registers read zero.
// - bit 6 zero shuts all switches on overvoltage; one suppresses it.
// - bit 5 zero shuts all switches on undervoltage; one suppresses it.
// - bit 4 one restores switches after supply fault, zero leaves them off.
// - first source register: bits 2:0 switch one, 6:4 switch two, six codes.
// - second source register: bits 2:0 switch three, 6:4 switch four.
// - overcurrent or overtemperature clears that switch's source field to off.
// - power-on and soft reset load zero into all five registers.
// - timer a uses timer b's codes in its own register.
// - duty value is a fraction of 255; zero off, all ones always on.
// - duty rate select 0 gives 200 Hz, 1 gives 400 Hz.
`timescale 1ns/1ps
module high_side_switch_cyclic_control (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       soft_reset,
    input  wire logic [6:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    output logic      [7:0] reg_rdata,
    input  wire logic       overvoltage,
    input  wire logic       undervoltage,
    input  wire logic [3:0] overcurrent,
    input  wire logic [3:0] overtemperature,
    input  wire logic       restart_clear,
    input  wire logic       cyclic_sense_a,
    input  wire logic       cyclic_sense_b,
    input  wire logic [7:0] duty_value_a,
    input  wire logic [7:0] duty_value_b,
    input  wire logic       duty_rate_select_a,
    input  wire logic       duty_rate_select_b,
    output logic      [3:0] switch_output
);
    localparam int TW = hs_switch_pkg::TICK_W - 1;

    logic [7:0] cyclic_timer_a_control;
    logic [7:0] cyclic_timer_b_control;
    logic [7:0] switch_shutdown_control;
    logic [7:0] switch_source_select_a;
    logic [7:0] switch_source_select_b;
    logic [7:0] next_timer_a;
    logic [7:0] next_timer_b;
    logic [7:0] next_shutdown;
    logic [7:0] next_src_a;
    logic [7:0] next_src_b;
    logic [7:0] next_rdata;
    logic [3:0] next_switch;
    logic [3:0] clear_field;
    logic       supply_shut;
    logic       supply_shut_q;
    logic       fault_end;
    logic [TW:0] tick_count;
    logic [TW:0] next_tick_count;
    logic       tick;
    logic       timer_a_out;
    logic       timer_b_out;
    logic [9:0] duty_pre      [2];
    logic [9:0] next_duty_pre [2];
    logic [7:0] duty_phase      [2];
    logic [7:0] next_duty_phase [2];
    logic [1:0] duty_out;
    logic [1:0] duty_rate;
    logic [7:0] duty_val [2];

    function automatic logic drive_from(input logic [2:0] code, input logic ta, input logic tb,
                                        input logic [1:0] duty);
        case (code)
            hs_switch_pkg::SRC_ON:      drive_from = 1'b1;
            hs_switch_pkg::SRC_TIMER_A: drive_from = ta;
            hs_switch_pkg::SRC_TIMER_B: drive_from = tb;
            hs_switch_pkg::SRC_DUTY_A:  drive_from = duty[0];
            hs_switch_pkg::SRC_DUTY_B:  drive_from = duty[1];
            default:                    drive_from = 1'b0;
        endcase
    endfunction

    // shared 0.1 ms timebase
    always_comb begin
        tick            = (tick_count == (TW + 1)'(hs_switch_pkg::TICK_CYCLES - 1));
        next_tick_count = tick ? '0 : tick_count + 1'b1;
    end

    cyclic_timer timer_a (
        .mclk         (mclk),
        .srst         (srst),
        .tick         (tick),
        .on_code      (cyclic_timer_a_control[hs_switch_pkg::ON_LSB +: 3]),
        .per_code     (cyclic_timer_a_control[hs_switch_pkg::PER_LSB +: 3]),
        .timer_output (timer_a_out)
    );

    cyclic_timer timer_b (
        .mclk         (mclk),
        .srst         (srst),
        .tick         (tick),
        .on_code      (cyclic_timer_b_control[hs_switch_pkg::ON_LSB +: 3]),
        .per_code     (cyclic_timer_b_control[hs_switch_pkg::PER_LSB +: 3]),
        .timer_output (timer_b_out)
    );

    // duty generators: 255 steps per cycle, step length set by rate select
    always_comb begin
        duty_rate   = {duty_rate_select_b, duty_rate_select_a};
        duty_val[0] = duty_value_a;
        duty_val[1] = duty_value_b;
        for (int i = 0; i < 2; i++) begin
            if (duty_pre[i] >= (duty_rate[i] ? 10'(hs_switch_pkg::DUTY_HI_STEP - 1)
                                             : 10'(hs_switch_pkg::DUTY_LO_STEP - 1))) begin
                next_duty_pre[i]   = 10'h000;
                next_duty_phase[i] = (duty_phase[i] == 8'(hs_switch_pkg::DUTY_STEPS - 1))
                                     ? 8'h00 : duty_phase[i] + 8'h01;
            end else begin
                next_duty_pre[i]   = duty_pre[i] + 10'h001;
                next_duty_phase[i] = duty_phase[i];
            end
            // phase never reaches 255, so full scale stays on
            duty_out[i] = (duty_phase[i] < duty_val[i]);
        end
    end

    always_comb begin
        supply_shut = (overvoltage  && !switch_shutdown_control[hs_switch_pkg::OVERVOLT_DIS_BIT])
                   || (undervoltage && !switch_shutdown_control[hs_switch_pkg::UNDERVOLT_DIS_BIT]);
        fault_end   = supply_shut_q && !supply_shut;
        clear_field = overcurrent | overtemperature;

        next_timer_a  = cyclic_timer_a_control;
        next_timer_b  = cyclic_timer_b_control;
        next_shutdown = switch_shutdown_control;
        next_src_a    = switch_source_select_a;
        next_src_b    = switch_source_select_b;
        if (reg_write) begin
            case (reg_addr)
                hs_switch_pkg::ADDR_TIMER_A:  next_timer_a  = reg_wdata & hs_switch_pkg::TIMER_MASK;
                hs_switch_pkg::ADDR_TIMER_B:  next_timer_b  = reg_wdata & hs_switch_pkg::TIMER_MASK;
                hs_switch_pkg::ADDR_SHUTDOWN: next_shutdown = reg_wdata & hs_switch_pkg::SHUTDOWN_MASK;
                hs_switch_pkg::ADDR_SRC_A:    next_src_a    = reg_wdata & hs_switch_pkg::SRC_MASK;
                hs_switch_pkg::ADDR_SRC_B:    next_src_b    = reg_wdata & hs_switch_pkg::SRC_MASK;
                default: ;
            endcase
        end
        if (restart_clear) begin
            next_src_a = hs_switch_pkg::REG_RESET;
            next_src_b = hs_switch_pkg::REG_RESET;
            // stale timer settings would fake a sensed switch
            if (cyclic_sense_a) begin
                next_timer_a = hs_switch_pkg::REG_RESET;
            end
            if (cyclic_sense_b) begin
                next_timer_b = hs_switch_pkg::REG_RESET;
            end
        end
        if (fault_end && !switch_shutdown_control[hs_switch_pkg::REC_BIT]) begin
            next_src_a = hs_switch_pkg::REG_RESET;
            next_src_b = hs_switch_pkg::REG_RESET;
        end
        // hardware clear beats a same-cycle write
        if (clear_field[0]) next_src_a[2:0] = hs_switch_pkg::SRC_OFF;
        if (clear_field[1]) next_src_a[6:4] = hs_switch_pkg::SRC_OFF;
        if (clear_field[2]) next_src_b[2:0] = hs_switch_pkg::SRC_OFF;
        if (clear_field[3]) next_src_b[6:4] = hs_switch_pkg::SRC_OFF;
        if (soft_reset) begin
            next_timer_a  = hs_switch_pkg::REG_RESET;
            next_timer_b  = hs_switch_pkg::REG_RESET;
            next_shutdown = hs_switch_pkg::REG_RESET;
            next_src_a    = hs_switch_pkg::REG_RESET;
            next_src_b    = hs_switch_pkg::REG_RESET;
        end

        case (reg_addr)
            hs_switch_pkg::ADDR_TIMER_A:  next_rdata = cyclic_timer_a_control;
            hs_switch_pkg::ADDR_TIMER_B:  next_rdata = cyclic_timer_b_control;
            hs_switch_pkg::ADDR_SHUTDOWN: next_rdata = switch_shutdown_control;
            hs_switch_pkg::ADDR_SRC_A:    next_rdata = switch_source_select_a;
            hs_switch_pkg::ADDR_SRC_B:    next_rdata = switch_source_select_b;
            default:                      next_rdata = 8'h00;
        endcase

        next_switch[0] = drive_from(switch_source_select_a[2:0], timer_a_out, timer_b_out, duty_out);
        next_switch[1] = drive_from(switch_source_select_a[6:4], timer_a_out, timer_b_out, duty_out);
        next_switch[2] = drive_from(switch_source_select_b[2:0], timer_a_out, timer_b_out, duty_out);
        next_switch[3] = drive_from(switch_source_select_b[6:4], timer_a_out, timer_b_out, duty_out);
        if (supply_shut) begin
            next_switch = 4'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cyclic_timer_a_control  <= hs_switch_pkg::REG_RESET;
            cyclic_timer_b_control  <= hs_switch_pkg::REG_RESET;
            switch_shutdown_control <= hs_switch_pkg::REG_RESET;
            switch_source_select_a  <= hs_switch_pkg::REG_RESET;
            switch_source_select_b  <= hs_switch_pkg::REG_RESET;
            supply_shut_q           <= 1'b0;
            reg_rdata               <= 8'h00;
            switch_output           <= 4'h0;
            tick_count              <= '0;
            duty_pre                <= '{2{10'h000}};
            duty_phase              <= '{2{8'h00}};
        end else begin
            cyclic_timer_a_control  <= next_timer_a;
            cyclic_timer_b_control  <= next_timer_b;
            switch_shutdown_control <= next_shutdown;
            switch_source_select_a  <= next_src_a;
            switch_source_select_b  <= next_src_b;
            supply_shut_q           <= supply_shut;
            reg_rdata               <= next_rdata;
            switch_output           <= next_switch;
            tick_count              <= next_tick_count;
            duty_pre                <= next_duty_pre;
            duty_phase              <= next_duty_phase;
        end
    end

    sequence s_fault_gone;
        supply_shut_q && !supply_shut;
    endsequence

    property p_overvolt_off;
        @(posedge mclk) disable iff (srst)
        (overvoltage && !switch_shutdown_control[hs_switch_pkg::OVERVOLT_DIS_BIT]) |=> (switch_output == 4'h0);
    endproperty
    a_overvolt_off: assert property (p_overvolt_off) else $error("switches on during overvoltage");

    property p_undervolt_off;
        @(posedge mclk) disable iff (srst)
        (undervoltage && !switch_shutdown_control[hs_switch_pkg::UNDERVOLT_DIS_BIT]) |=> (switch_output == 4'h0);
    endproperty
    a_undervolt_off: assert property (p_undervolt_off) else $error("switches on during undervoltage");

    property p_no_recover;
        @(posedge mclk) disable iff (srst)
        (s_fault_gone and !switch_shutdown_control[hs_switch_pkg::REC_BIT] and !reg_write)
        |=> (switch_source_select_a == 8'h00 && switch_source_select_b == 8'h00) ##1 (switch_output == 4'h0);
    endproperty
    a_no_recover: assert property (p_no_recover) else $error("switches not left off after fault");

    property p_oc_clear;
        @(posedge mclk) disable iff (srst)
        (overcurrent[0] || overtemperature[0]) |=> (switch_source_select_a[2:0] == 3'h0);
    endproperty
    a_oc_clear: assert property (p_oc_clear) else $error("switch one source not cleared");

    property p_soft_reset;
        @(posedge mclk) disable iff (srst)
        soft_reset |=> (cyclic_timer_b_control == 8'h00 && switch_shutdown_control == 8'h00
                        && switch_source_select_a == 8'h00 && switch_source_select_b == 8'h00);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not clear registers");

    property p_reserved_zero;
        @(posedge mclk) disable iff (srst)
        (reg_addr == hs_switch_pkg::ADDR_SHUTDOWN) |=> (reg_rdata[7] == 1'b0 && reg_rdata[3:0] == 4'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

    property p_forced_on;
        @(posedge mclk) disable iff (srst)
        (switch_source_select_b[6:4] == 3'h1 && !supply_shut) |=> switch_output[3];
    endproperty
    a_forced_on: assert property (p_forced_on) else $error("switch four not on");

    property p_restart_timer;
        @(posedge mclk) disable iff (srst)
        (restart_clear && cyclic_sense_b && !soft_reset) |=> (cyclic_timer_b_control == 8'h00);
    endproperty
    a_restart_timer: assert property (p_restart_timer) else $error("timer b kept after restart clear");

endmodule // high_side_switch_cyclic_control

/* design/hs_switch_pkg.sv */
package hs_switch_pkg;

    localparam int CLK_HZ       = 40_000_000;
    localparam int TICK_US      = 100;
    localparam int TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_US;
    localparam int TICK_W       = 12;

    localparam logic [6:0] ADDR_TIMER_A  = 7'h0C;
    localparam logic [6:0] ADDR_TIMER_B  = 7'h0D;
    localparam logic [6:0] ADDR_SHUTDOWN = 7'h10;
    localparam logic [6:0] ADDR_SRC_A    = 7'h14;
    localparam logic [6:0] ADDR_SRC_B    = 7'h15;

    localparam logic [7:0] REG_RESET     = 8'h00;
    localparam logic [7:0] TIMER_MASK    = 8'h77;
    localparam logic [7:0] SHUTDOWN_MASK = 8'h70;
    localparam logic [7:0] SRC_MASK      = 8'h77;

    localparam int ON_LSB            = 4;
    localparam int PER_LSB           = 0;
    localparam int OVERVOLT_DIS_BIT  = 6;
    localparam int UNDERVOLT_DIS_BIT = 5;
    localparam int REC_BIT           = 4;

    localparam logic [2:0] ON_STOP     = 3'h0;
    localparam logic [2:0] ON_HIGH     = 3'h6;
    localparam logic [2:0] PER_RSVD    = 3'h7;

    localparam logic [2:0] SRC_OFF     = 3'h0;
    localparam logic [2:0] SRC_ON      = 3'h1;
    localparam logic [2:0] SRC_TIMER_A = 3'h2;
    localparam logic [2:0] SRC_TIMER_B = 3'h3;
    localparam logic [2:0] SRC_DUTY_A  = 3'h4;
    localparam logic [2:0] SRC_DUTY_B  = 3'h5;

    localparam int ON_T1_US  = 100;
    localparam int ON_T2_US  = 300;
    localparam int ON_T3_US  = 1000;
    localparam int ON_T4_US  = 10000;
    localparam int ON_T5_US  = 20000;
    localparam int PER_T0_MS = 10;
    localparam int PER_T1_MS = 20;
    localparam int PER_T2_MS = 50;
    localparam int PER_T3_MS = 100;
    localparam int PER_T4_MS = 200;
    localparam int PER_T5_MS = 1000;
    localparam int PER_T6_MS = 2000;

    localparam int DUTY_STEPS   = 255;
    localparam int DUTY_LO_HZ   = 200;
    localparam int DUTY_HI_HZ   = 400;
    localparam int DUTY_LO_STEP = CLK_HZ / (DUTY_LO_HZ * DUTY_STEPS);
    localparam int DUTY_HI_STEP = CLK_HZ / (DUTY_HI_HZ * DUTY_STEPS);

    function automatic logic [14:0] on_ticks(input logic [2:0] code);
        case (code)
            3'h1:    on_ticks = 15'(ON_T1_US / TICK_US);
            3'h2:    on_ticks = 15'(ON_T2_US / TICK_US);
            3'h3:    on_ticks = 15'(ON_T3_US / TICK_US);
            3'h4:    on_ticks = 15'(ON_T4_US / TICK_US);
            3'h5:    on_ticks = 15'(ON_T5_US / TICK_US);
            default: on_ticks = 15'h0000;
        endcase
    endfunction

    function automatic logic [14:0] per_ticks(input logic [2:0] code);
        case (code)
            3'h0:    per_ticks = 15'(PER_T0_MS * 1000 / TICK_US);
            3'h1:    per_ticks = 15'(PER_T1_MS * 1000 / TICK_US);
            3'h2:    per_ticks = 15'(PER_T2_MS * 1000 / TICK_US);
            3'h3:    per_ticks = 15'(PER_T3_MS * 1000 / TICK_US);
            3'h4:    per_ticks = 15'(PER_T4_MS * 1000 / TICK_US);
            3'h5:    per_ticks = 15'(PER_T5_MS * 1000 / TICK_US);
            3'h6:    per_ticks = 15'(PER_T6_MS * 1000 / TICK_US);
            default: per_ticks = 15'h0000;
        endcase
    endfunction

endpackage

/* design/cyclic_timer.sv */
`timescale 1ns/1ps
module cyclic_timer (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic       tick,
    input  wire logic [2:0] on_code,
    input  wire logic [2:0] per_code,
    output logic            timer_output
);
    typedef enum logic [2:0] {
        ST_STOP = 3'b001,
        ST_HIGH = 3'b010,
        ST_RUN  = 3'b100
    } timer_state_t;

    timer_state_t state;
    timer_state_t next_state;
    logic [14:0]  count;
    logic [14:0]  next_count;
    logic [5:0]   cfg;
    logic         next_out;
    logic         runnable;
    logic         cfg_changed;

    always_comb begin
        runnable    = (on_code != hs_switch_pkg::ON_STOP) && (on_code < hs_switch_pkg::ON_HIGH)
                      && (per_code != hs_switch_pkg::PER_RSVD);
        cfg_changed = (cfg != {on_code, per_code});
        if (runnable) begin
            next_state = ST_RUN;
        end else if (on_code == hs_switch_pkg::ON_HIGH) begin
            next_state = ST_HIGH;
        end else begin
            next_state = ST_STOP;
        end
        // a new setting restarts the cycle with the on phase
        if (next_state != ST_RUN || state != ST_RUN || cfg_changed) begin
            next_count = 15'h0000;
        end else if (tick) begin
            next_count = (count == hs_switch_pkg::per_ticks(per_code) - 15'h0001) ? 15'h0000 : count + 15'h0001;
        end else begin
            next_count = count;
        end
        case (next_state)
            ST_RUN:  next_out = (next_count < hs_switch_pkg::on_ticks(on_code));
            ST_HIGH: next_out = 1'b1;
            ST_STOP: next_out = 1'b0;
            default: next_out = 1'b0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state        <= ST_STOP;
            count        <= 15'h0000;
            cfg          <= 6'h00;
            timer_output <= 1'b0;
        end else begin
            state        <= next_state;
            count        <= next_count;
            cfg          <= {on_code, per_code};
            timer_output <= next_out;
        end
    end

    sequence s_run_written;
        (cfg_changed && runnable);
    endsequence

    property p_hold_high;
        @(posedge mclk) disable iff (srst)
        (on_code == hs_switch_pkg::ON_HIGH) |=> (timer_output && count == 15'h0000);
    endproperty
    a_hold_high: assert property (p_hold_high) else $error("held-high code did not force output");

    property p_stop_low;
        @(posedge mclk) disable iff (srst)
        (on_code == hs_switch_pkg::ON_STOP || on_code == 3'h7) |=> !timer_output;
    endproperty
    a_stop_low: assert property (p_stop_low) else $error("stopped timer output not low");

    property p_auto_start;
        @(posedge mclk) disable iff (srst)
        s_run_written |=> (timer_output && state == ST_RUN);
    endproperty
    a_auto_start: assert property (p_auto_start) else $error("timer did not start on write");

endmodule // cyclic_timer

/* verification/switch_stage_model.sv */
`timescale 1ns/1ps
module switch_stage_model (
    input  wire logic [3:0] switch_output,
    input  wire logic [3:0] short_req,
    input  wire logic [3:0] hot_req,
    output logic      [3:0] overcurrent,
    output logic      [3:0] overtemperature
);
    // a stage that is off carries no current, so it cannot report a fault
    assign overcurrent     = short_req & switch_output;
    assign overtemperature = hot_req & switch_output;
endmodule // switch_stage_model

/* verification/high_side_switch_cyclic_control_test.sv */
`timescale 1ns/1ps
module high_side_switch_cyclic_control_test;
    logic mclk = 0, srst = 1, soft_reset = 0, reg_write = 0, supply_over = 0, supply_under = 0;
    logic rclr = 0, cs_a = 0, cs_b = 0, drs_a = 0, drs_b = 0;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, dva = 8'h00, dvb = 8'h00;
    logic [3:0] switch_output, oc, ot, short_req = 4'h0, hot_req = 4'h0;
    int error_cnt = 0, n_tests = 0, cnt;
    logic [7:0] mdl [int];
    always #12.5 mclk = ~mclk;
    switch_stage_model stage (.switch_output(switch_output), .short_req(short_req), .hot_req(hot_req),
        .overcurrent(oc), .overtemperature(ot));
    high_side_switch_cyclic_control uut (.mclk(mclk), .srst(srst), .soft_reset(soft_reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata),
        .overvoltage(supply_over), .undervoltage(supply_under), .overcurrent(oc), .overtemperature(ot),
        .restart_clear(rclr), .cyclic_sense_a(cs_a), .cyclic_sense_b(cs_b), .duty_value_a(dva),
        .duty_value_b(dvb), .duty_rate_select_a(drs_a), .duty_rate_select_b(drs_b),
        .switch_output(switch_output));
    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        step(1);
        reg_write = 1'b0;
        // one idle edge between strobes
        step(1);
        // unmapped places keep nothing
        if (mdl.exists(a))
            mdl[a] = d & ((a == hs_switch_pkg::ADDR_SHUTDOWN) ? hs_switch_pkg::SHUTDOWN_MASK
                                                              : hs_switch_pkg::SRC_MASK);
    endtask
    task automatic rd(input logic [6:0] a);
        reg_addr = a;
        step(1);
        chk($sformatf("reg %h", a), mdl.exists(a) ? mdl[a] : 8'h00, reg_rdata);
    endtask
    task automatic rd_all();
        foreach (mdl[a]) rd(7'(a));
        rd(7'h11);
    endtask
    task automatic out_chk(input logic [3:0] exp);
        step(2);
        chk("switch_output", {4'h0, exp}, {4'h0, switch_output});
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] on_map;
        on_map = 8'h16;
        mdl[7'h0C] = 0; mdl[7'h0D] = 0; mdl[7'h10] = 0; mdl[7'h14] = 0; mdl[7'h15] = 0;
        void'($urandom(32'h2B47));
        drs_a = 1'($urandom);
        drs_b = 1'($urandom);
        step(5);
        srst = 1'b0;
        rd_all();
        for (int i = 0; i < 12; i++) begin
            wr((i % 6 == 5) ? 7'h11 : 7'(i % 5 == 4 ? 7'h15 : 7'h0C + (i % 4) * 4), 8'($urandom));
            rd(reg_addr);
        end
        soft_reset = 1'b1;
        step(1);
        soft_reset = 1'b0;
        foreach (mdl[a]) mdl[a] = 8'h00;
        rd_all();
        dva = 8'hFF;
        wr(7'h0C, 8'h60);
        for (int c = 0; c < 8; c++) begin
            wr(7'h14, 8'(c));
            wr(7'h15, 8'(c << 4));
            out_chk({on_map[c], 2'b00, on_map[c]});
        end
        wr(7'h14, 8'h03);
        wr(7'h0D, 8'h60);
        out_chk(4'h1);
        wr(7'h0D, 8'h17);
        out_chk(4'h0);
        wr(7'h0D, 8'h10);
        step(1);
        cnt = 0;
        while (switch_output[0] === 1'b1 && cnt < 4100) begin
            cnt++;
            step(1);
        end
        chk("on cycles", 8'h01, {7'h00, cnt >= 1 && cnt <= 4001});
        out_chk(4'h0);
        wr(7'h14, 8'h01);
        wr(7'h15, 8'h11);
        short_req = 4'h4;
        step(1);
        short_req = 4'h0;
        hot_req = 4'h8;
        step(1);
        hot_req = 4'h0;
        mdl[7'h15] = 8'h00;
        rd(7'h15);
        supply_over = 1'b1;
        out_chk(4'h0);
        supply_over = 1'b0;
        // the source clear lands on the edge after the fault ends
        step(1);
        mdl[7'h14] = 8'h00;
        rd(7'h14);
        wr(7'h10, 8'hDF);
        wr(7'h14, 8'h01);
        supply_over = 1'b1;
        out_chk(4'h1);
        wr(7'h10, 8'h10);
        out_chk(4'h0);
        supply_over = 1'b0;
        out_chk(4'h1);
        wr(7'h10, 8'h30);
        supply_under = 1'b1;
        out_chk(4'h1);
        wr(7'h10, 8'h10);
        out_chk(4'h0);
        supply_under = 1'b0;
        out_chk(4'h1);
        rd_all();
        wr(7'h0D, 8'h25);
        cs_b = 1'b1;
        rclr = 1'b1;
        step(1);
        rclr = 1'b0;
        mdl[7'h0D] = 8'h00; mdl[7'h14] = 8'h00; mdl[7'h15] = 8'h00;
        rd_all();
        cs_a = 1'b1;
        rclr = 1'b1;
        step(1);
        rclr = 1'b0;
        mdl[7'h0C] = 8'h00;
        rd(7'h0C);
        tally_and_finish();
    end
endmodule // high_side_switch_cyclic_control_test
